// ==== sacs_pkg.sv ====
// sacs_pkg: constants, pin bundle and states for the serial converter sequencer
// assumes: one core clock of 50 MHz; all pins arrive asynchronously
package sacs_pkg;
    localparam int RES_W       = 8;   // result width
    localparam int ADDR_W      = 4;   // channel address width
    localparam int FIFO_DEPTH  = 16;  // result buffer depth
    localparam int CONV_CYC    = 36;  // conversion length in conversion-clock periods
    localparam int STEP_CYC    = 4;   // conversion-clock periods per decided bit
    localparam int FILTER_CYC  = 3;   // select filter length in conversion-clock periods
    localparam int START_FALL  = 8;   // transfer-clock fall that starts a conversion
    localparam int SHIFT_FALLS = 7;   // falls that shift the low result bits
    localparam int ADDR_RISES  = 4;   // rises that carry the address
    localparam logic [ADDR_W-1:0] SELFTEST_CH = 4'hb; // internal test voltage channel
    localparam logic [5:0] CNT_ZERO = 6'h00;
    localparam logic [5:0] CNT_ONE  = 6'h01;

    // synchronised pin levels
    typedef struct packed {
        logic cs_n;
        logic io_clk;
        logic addr;
        logic conv_clk;
        logic comp;
    } sacs_pins_t;

    typedef enum logic [1:0] {
        SACS_IDLE,
        SACS_CONVERT,
        SACS_PUSH
    } sacs_state_t;

    // channel code to multiplexer select; spare codes map to the test voltage
    function automatic logic [ADDR_W-1:0] sacs_chan(input logic [ADDR_W-1:0] code);
        return (code > SELFTEST_CH) ? SELFTEST_CH : code;
    endfunction

    function automatic logic sacs_rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

    function automatic logic sacs_fall(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction
endpackage

// ==== sacs_fifo.sv ====
// sacs_fifo: parameterised synchronous result buffer, valid/ready both sides
// assumes: single clock, clock enable freezes all state
`timescale 1ns/1ps
module sacs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    input  wire logic             ce_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
    logic [PW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    // honest flags straight from the occupancy count
    assign in_ready_out  = (cnt_r != DEPTH[PW:0]);
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rd_r];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;

    // pointer and count update
    always_comb begin
        wr_nxt  = push ? PW'(wr_r + 1'b1) : wr_r;
        rd_nxt  = pop  ? PW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = (PW+1)'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = (PW+1)'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else if (ce_in) begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage needs no reset; data is only read while valid
    always_ff @(posedge clk_in) begin
        if (ce_in && push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end
endmodule // sacs_fifo

// ==== sacs_top.sv ====
// sacs_top: control of an 8-bit successive-approximation converter with serial link
// assumes: pins and conversion clock are asynchronous to clk_in and much slower
// Functional notes
// - a conversion starts on the eighth transfer-clock fall after select low and lasts 36 conversion-clock periods.
// - that conversion uses the channel held in the address store at that fall.
// - select going low puts the previous result's top bit on the output with no transfer-clock edge.
// - the first seven transfer-clock falls shift out result bits 6 down to 0.
// - for up to three conversion-clock periods after a select fall the other control inputs are ignored.
// - the address picks one of eleven external inputs or the internal self-test voltage.
// - each result is 8 bits, found by successive approximation one bit per step.
// - the result output is three-state so several devices can share a line.
// - the previous result is shifted out while the next address is shifted in.
// - sampling ends under host timing, at the eighth transfer-clock fall.
// - address bits are taken on the transfer-clock rise.
`timescale 1ns/1ps
module sacs_top (
    // clock, reset, enable
    input  wire logic                         clk_in,
    input  wire logic                         reset_n_in,
    input  wire logic                         ce_in,
    // host link pins
    input  wire logic                         cs_n_in,
    input  wire logic                         io_clk_in,
    input  wire logic                         addr_in,
    output logic                              data_out,
    output logic                              data_oe_out,
    // conversion clock pin
    input  wire logic                         conv_clk_in,
    // analog front end
    input  wire logic                         comp_in,
    output logic [sacs_pkg::ADDR_W-1:0]       chan_sel_out,
    output logic                              sample_out,
    output logic [sacs_pkg::RES_W-1:0]        dac_code_out,
    output logic                              busy_out
);
    import sacs_pkg::*;

    // pin synchronisers: first stage feeds only the second
    sacs_pins_t s1_r, s2_r, s3_r;
    sacs_pins_t pins_raw;
    assign pins_raw = '{cs_n: cs_n_in, io_clk: io_clk_in, addr: addr_in,
                        conv_clk: conv_clk_in, comp: comp_in};

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_r <= '{cs_n: 1'b1, default: 1'b0};
            s2_r <= '{cs_n: 1'b1, default: 1'b0};
            s3_r <= '{cs_n: 1'b1, default: 1'b0};
        end else if (ce_in) begin
            s1_r <= pins_raw;
            s2_r <= s1_r;
            s3_r <= s2_r; // previous value for edge finding
        end
    end

    // edge events on the synchronised levels
    logic cs_fall, io_rise, io_fall, cv_rise;
    assign cs_fall = sacs_fall(s3_r.cs_n, s2_r.cs_n);
    assign io_rise = sacs_rise(s3_r.io_clk, s2_r.io_clk);
    assign io_fall = sacs_fall(s3_r.io_clk, s2_r.io_clk);
    assign cv_rise = sacs_rise(s3_r.conv_clk, s2_r.conv_clk);

    // link side state
    logic [1:0]        filt_r, filt_nxt;
    logic [3:0]        falls_r, falls_nxt, rises_r, rises_nxt;
    logic [RES_W-1:0]  shift_r, shift_nxt, last_r, last_nxt;
    logic [ADDR_W-1:0] ashift_r, ashift_nxt, astore_r, astore_nxt;
    logic              start;
    logic              fifo_pop;
    logic              fifo_valid;
    logic [RES_W-1:0]  fifo_data;
    logic              link_ok;
    sacs_state_t       state_r, state_nxt;

    // transfer edges count only once the select filter has run out
    assign link_ok = !s2_r.cs_n && (filt_r == 2'h0) && !cs_fall;
    assign start   = link_ok && io_fall && (falls_r == 4'(START_FALL - 1))
                     && (state_r == SACS_IDLE);
    assign fifo_pop = cs_fall && fifo_valid;

    // link side next values: filter, edge counts, result and address shifters
    always_comb begin
        filt_nxt   = filt_r;
        falls_nxt  = falls_r;
        rises_nxt  = rises_r;
        shift_nxt  = shift_r;
        last_nxt   = last_r;
        ashift_nxt = ashift_r;
        astore_nxt = astore_r;
        if (cs_fall) begin
            // new access: load the oldest unread result, else the last one, top bit out at once
            filt_nxt  = 2'(FILTER_CYC);
            falls_nxt = 4'h0;
            rises_nxt = 4'h0;
            if (fifo_valid) begin
                shift_nxt = fifo_data;
                last_nxt  = fifo_data;
            end else begin
                shift_nxt = last_r;
            end
        end else if (!s2_r.cs_n) begin
            if (filt_r != 2'h0 && cv_rise) begin
                filt_nxt = 2'(filt_r - 2'h1);
            end
            if (link_ok && io_rise && rises_r < 4'(ADDR_RISES)) begin
                // address in, msb first, while the result goes out
                ashift_nxt = {ashift_r[ADDR_W-2:0], s2_r.addr};
                rises_nxt  = 4'(rises_r + 4'h1);
                if (rises_r == 4'(ADDR_RISES - 1)) begin
                    astore_nxt = {ashift_r[ADDR_W-2:0], s2_r.addr};
                end
            end
            if (link_ok && io_fall && falls_r < 4'(START_FALL)) begin
                falls_nxt = 4'(falls_r + 4'h1);
                if (falls_r < 4'(SHIFT_FALLS)) begin
                    shift_nxt = {shift_r[RES_W-2:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            filt_r   <= 2'h0;
            falls_r  <= 4'h0;
            rises_r  <= 4'h0;
            shift_r  <= 8'h00;
            last_r   <= 8'h00;
            ashift_r <= 4'h0;
            astore_r <= 4'h0;
        end else if (ce_in) begin
            filt_r   <= filt_nxt;
            falls_r  <= falls_nxt;
            rises_r  <= rises_nxt;
            shift_r  <= shift_nxt;
            last_r   <= last_nxt;
            ashift_r <= ashift_nxt;
            astore_r <= astore_nxt;
        end
    end

    // conversion side state
    logic [5:0]        ccnt_r, ccnt_nxt;
    logic [RES_W-1:0]  sar_r, sar_nxt;
    logic [2:0]        bit_r, bit_nxt;
    logic [ADDR_W-1:0] chan_r, chan_nxt;
    logic              samp_r, samp_nxt;
    logic              fifo_ready;

    // sampling runs while idle; the host's eighth fall closes it
    always_comb begin
        state_nxt = state_r;
        ccnt_nxt  = ccnt_r;
        sar_nxt   = sar_r;
        bit_nxt   = bit_r;
        chan_nxt  = chan_r;
        samp_nxt  = samp_r;
        unique case (state_r)
            SACS_IDLE: begin
                samp_nxt = 1'b1;
                chan_nxt = sacs_chan(astore_r);
                if (start) begin
                    chan_nxt  = sacs_chan(astore_r);
                    samp_nxt  = 1'b0;
                    ccnt_nxt  = CNT_ZERO;
                    bit_nxt   = 3'(RES_W - 1);
                    sar_nxt   = 8'h80;                                   // first trial at midscale
                    state_nxt = SACS_CONVERT;
                end
            end
            SACS_CONVERT: begin
                if (cv_rise) begin
                    ccnt_nxt = 6'(ccnt_r + CNT_ONE);
                    // decide one bit at the end of each step, then try the next
                    if (ccnt_r < 6'(STEP_CYC * RES_W) &&
                        ccnt_r[1:0] == 2'(STEP_CYC - 1)) begin
                        sar_nxt[bit_r] = s2_r.comp;
                        if (bit_r != 3'h0) begin
                            sar_nxt[bit_r - 3'h1] = 1'b1;
                            bit_nxt = 3'(bit_r - 3'h1);
                        end
                    end
                    if (ccnt_r == 6'(CONV_CYC - 1)) begin
                        state_nxt = SACS_PUSH;
                    end
                end
            end
            SACS_PUSH: begin
                // a full buffer holds the converter here until the host reads
                if (fifo_ready) begin
                    state_nxt = SACS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= SACS_IDLE;
            ccnt_r  <= CNT_ZERO;
            sar_r   <= 8'h00;
            bit_r   <= 3'h0;
            chan_r  <= 4'h0;
            samp_r  <= 1'b0;
        end else if (ce_in) begin
            state_r <= state_nxt;
            ccnt_r  <= ccnt_nxt;
            sar_r   <= sar_nxt;
            bit_r   <= bit_nxt;
            chan_r  <= chan_nxt;
            samp_r  <= samp_nxt;
        end
    end

    // results queue up between converter and link
    sacs_fifo #(
        .WIDTH (RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .ce_in         (ce_in),
        .in_valid_in   (state_r == SACS_PUSH),
        .in_ready_out  (fifo_ready),
        .in_data_in    (sar_r),
        .out_valid_out (fifo_valid),
        .out_ready_in  (fifo_pop),
        .out_data_out  (fifo_data)
    );

    // output drive: floats with select high, shared-line friendly
    assign data_out     = shift_r[RES_W-1];
    assign data_oe_out  = !s2_r.cs_n;
    assign chan_sel_out = chan_r;
    assign sample_out   = samp_r;
    assign dac_code_out = sar_r;
    assign busy_out     = (state_r != SACS_IDLE);
endmodule // sacs_top

// ==== sacs_top_asserts.sv ====
// sacs_top_asserts: port-level properties of the converter sequencer
// assumes: bound to sacs_top; conversion clock far slower than clk_in
`timescale 1ns/1ps
module sacs_top_asserts (
    // core
    input wire logic                        clk_in,
    input wire logic                        reset_n_in,
    input wire logic                        ce_in,
    // link and converter
    input wire logic                        cs_n_in,
    input wire logic                        io_clk_in,
    input wire logic                        addr_in,
    input wire logic                        data_out,
    input wire logic                        data_oe_out,
    input wire logic                        conv_clk_in,
    input wire logic                        comp_in,
    input wire logic [sacs_pkg::ADDR_W-1:0] chan_sel_out,
    input wire logic                        sample_out,
    input wire logic [sacs_pkg::RES_W-1:0]  dac_code_out,
    input wire logic                        busy_out
);
    logic       conv_q_r, conv_q_nxt;
    logic [6:0] rises_r, rises_nxt;
    // raw pin rises while busy; the raw pin leads the synced count, so allow one either way
    always_comb begin
        conv_q_nxt = conv_clk_in;
        rises_nxt  = busy_out ? rises_r + {6'h00, conv_clk_in & ~conv_q_r} : 7'h00;
    end
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            conv_q_r <= 1'b0;
            rises_r  <= 7'h00;
        end else begin
            conv_q_r <= conv_q_nxt;
            rises_r  <= rises_nxt;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_oe_off: assert property (cs_n_in [*4] |-> !data_oe_out)
        else $error("output driven while deselected");
    a_oe_on: assert property (!cs_n_in [*4] |-> data_oe_out)
        else $error("output not driven while selected");
    a_data_hold: assert property ((!cs_n_in && io_clk_in) [*4] |=> $stable(data_out))
        else $error("result bit moved without a transfer clock fall");
    a_start_cause: assert property ($rose(busy_out) |-> data_oe_out && !io_clk_in)
        else $error("conversion began outside a selected clock fall");
    a_start_trial: assert property ($rose(busy_out) |-> dac_code_out == 8'h80 && !sample_out)
        else $error("conversion began with wrong trial or still sampling");
    a_chan_stable: assert property (busy_out && $past(busy_out) |-> $stable(chan_sel_out))
        else $error("channel moved during conversion");
    a_chan_range: assert property (chan_sel_out <= 4'hb)
        else $error("channel beyond the twelve inputs");
    a_conv_len: assert property ($fell(busy_out) |-> rises_r inside {[35:37]})
        else $error("conversion length not 36 conversion clocks");
    a_busy_bound: assert property (busy_out |-> rises_r < 7'h28)
        else $error("conversion overran");
    a_sample_idle: assert property (!busy_out [*3] |-> sample_out)
        else $error("not sampling while idle");
    c_start: cover property ($rose(busy_out));
    c_done: cover property ($fell(busy_out));
    c_deselect: cover property ($fell(data_oe_out));
endmodule // sacs_top_asserts

bind sacs_top sacs_top_asserts u_chk (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .cs_n_in(cs_n_in), .io_clk_in(io_clk_in), .addr_in(addr_in),
    .data_out(data_out), .data_oe_out(data_oe_out), .conv_clk_in(conv_clk_in),
    .comp_in(comp_in), .chan_sel_out(chan_sel_out), .sample_out(sample_out),
    .dac_code_out(dac_code_out), .busy_out(busy_out)
);

// ==== sacs_host.sv ====
// sacs_host: host side of the serial link, driven through its tasks
// assumes: clk_in is the bench clock; transfer clock 160 ns, idle low
`timescale 1ns/1ps
module sacs_host (
    // timing reference
    input  wire logic clk_in,
    // link pins
    output logic      cs_n_out,
    output logic      io_clk_out,
    output logic      addr_out,
    input  wire logic data_in
);
    initial begin
        cs_n_out   = 1'b1;
        io_clk_out = 1'b0;
        addr_out   = 1'b0;
    end
    // whole clocks, landing just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // one select-low frame; fewer than 8 rises makes a short, aborted frame
    task automatic frame(input logic [3:0] code, input bit early, input int rises,
                         output logic [7:0] res);
        cs_n_out = 1'b0;
        cyc(5);
        // stray pulse inside the select filter window
        if (early) begin
            io_clk_out = 1'b1;
            cyc(2);
            io_clk_out = 1'b0;
        end
        cyc(20); // setup past three conversion clocks
        for (int i = 0; i < 8; i++) begin
            res[7-i] = data_in; // result comes in as the address goes out
            if (i < rises) begin
                addr_out   = (i < 4) ? code[3-i] : ~addr_out;
                io_clk_out = 1'b1;
                cyc(4);
                io_clk_out = 1'b0;
                cyc(4);
            end
        end
        if (rises < 8)
            close(0);
    endtask
    // transfer clock stays low through the conversion before deselect
    task automatic close(input int n);
        // n covers 36 conversion clocks when converting
        // a zero wait keeps the usual one-nanosecond offset after the edge
        if (n > 0)
            cyc(n);
        cs_n_out = 1'b1; // only raised after conversion ends
        addr_out = ~addr_out; // released line shows no stale bit
        cyc(10);
    endtask
endmodule // sacs_host

// ==== tb_top.sv ====
// tb_top: self-checking bench for the converter sequencer and its buffer
// assumes: host model in sacs_host, checker bound by its own file
`timescale 1ns/1ps
module tb_top;
    import sacs_pkg::*;
    logic             clk_in = 1'b0, reset_n_in = 1'b0, conv_clk = 1'b0, comp = 1'b0;
    logic             cs_n, io_clk, addr, data, oe, samp, busy;
    logic [ADDR_W-1:0] chan;
    logic [RES_W-1:0] dac, r, target = 8'h00, prev = 8'h00;
    int               mismatches = 0, tests_run = 0;
    wire              data_pin = oe ? data : 1'bz; // three-state result line
    always #10 clk_in = ~clk_in;
    // conversion clock runs free, its edges kept off the core clock edges to avoid a race
    always begin
        #47 conv_clk = 1'b1;
        #50 conv_clk = 1'b0;
        #3;
    end
    // comparator: keep the trial bit while the input is at or above it
    always @(posedge clk_in) begin
        #1;
        comp = (dac <= target);
    end
    sacs_host host (.clk_in(clk_in), .cs_n_out(cs_n), .io_clk_out(io_clk),
                    .addr_out(addr), .data_in(data_pin));
    sacs_top uut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1),
        .cs_n_in(cs_n), .io_clk_in(io_clk), .addr_in(addr),
        .data_out(data), .data_oe_out(oe), .conv_clk_in(conv_clk),
        .comp_in(comp), .chan_sel_out(chan), .sample_out(samp),
        .dac_code_out(dac), .busy_out(busy));
    task automatic check(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // every code once; code 5 also carries a stray pulse in the filter window
    task automatic t_chan;
        for (int c = 0; c < 16; c++) begin
            target = {c[3:0], ~c[3:0]};
            host.frame(c[3:0], c == 5, 8, r);
            check("result", r, prev);
            check("chan", chan, (c > 11) ? 4'hb : c[3:0]);
            check("busy", busy, 1'b1);
            check("sample", samp, 1'b0);
            check("oe", oe, 1'b1);
            host.close(220);
            check("idle", {busy, oe, samp}, 3'h1);
            prev = target;
        end
        $display("t_chan done");
    endtask
    // aborted frame stores nothing and starts nothing
    task automatic t_short;
        host.frame(4'h3, 1'b0, 3, r);
        check("short_busy", busy, 1'b0);
        host.frame(4'h9, 1'b0, 8, r);
        check("short_result", r, prev);
        check("short_chan", chan, 4'h9);
        host.close(220);
        $display("t_short done");
    endtask
    // result buffer through the link: oldest result first, re-read once the buffer is empty
    task automatic t_fifo;
        target = 8'h5a;
        host.frame(4'h2, 1'b0, 8, r);
        check("fifo_old", r, prev);
        host.close(220);
        // seven clocks read the whole result but start no conversion
        host.frame(4'h2, 1'b0, 7, r);
        check("fifo_new", r, 8'h5a);
        check("fifo_busy", busy, 1'b0);
        host.frame(4'h2, 1'b0, 7, r);
        check("fifo_again", r, 8'h5a);
        check("fifo_chan", chan, 4'h2);
        $display("t_fifo done");
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        check("oe_rst", oe, 1'b0);
        check("busy_rst", busy, 1'b0);
        $display("t_reset done");
        #1 reset_n_in = 1'b1;
        host.cyc(4);
        t_chan();
        t_short();
        t_fifo();
        report_and_stop();
    end
    // watchdog: the run needs roughly 120 us
    initial begin
        #400000;
        mismatches++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // tb_top
